// ---- inc/phyclr_pkg.sv ----
package phyclr_pkg;
  // Clock and link timing
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int BETA_FREQ_KHZ = 98304;
  localparam int LEGACY_FREQ_KHZ = 49152;
  // Link clock half period in system cycles; the slow core clock scales both rates alike
  localparam int BETA_HALF_CYCLES = 1;
  localparam int LEGACY_HALF_CYCLES = BETA_HALF_CYCLES * BETA_FREQ_KHZ / LEGACY_FREQ_KHZ;
  // Link power status low times
  localparam int LPS_RESET_NS = 2600;
  localparam int LPS_DISABLE_NS = 26000;
  localparam int LPS_RESET_CYCLES = (LPS_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LPS_DISABLE_CYCLES = (LPS_DISABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LPS_CNT_WIDTH = 11;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_SERIAL = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;
  // Event bit positions
  localparam int EV_RESET_STATE = 0;
  localparam int EV_DISABLED = 1;
  localparam int EV_LINK_REQUEST = 2;
  localparam int EV_SERIAL_DONE = 3;
  localparam int EV_POWER_DOWN = 4;
  localparam int EV_COUNT = 5;
  // Field layouts
  localparam int TX_DATA_WIDTH = 8;
  localparam int TX_CTL_LSB = 8;
  localparam int SERIAL_WIDTH = 8;
  localparam logic [3:0] SERIAL_BITS = 4'h9;
  localparam logic [9:0] TXDATA_RESET = 10'h000;
  localparam logic [7:0] SERIAL_RESET = 8'h00;
  localparam logic [4:0] ENABLE_RESET = 5'h00;

  typedef enum logic [2:0]
  {
    LINK_DISABLED = 3'b001,
    LINK_RESET = 3'b010,
    LINK_ACTIVE = 3'b100
  } phyclr_link_state_type;
endpackage : phyclr_pkg

// ---- verilog/phyclr_top.sv ----
`timescale 1ns/1ps
// What this block does
// - With beta mode selected the link clock runs at the fast rate, aligned with outgoing data.
// - With beta mode deselected the link clock runs at half that rate; the transmit register is held at reset, so control and data stay zero.
// - Power-down stops the link logic; the cable-active monitor path and the status and enable registers keep running.
// - Power-down pulls the reset pin low and holds the control logic in reset meanwhile.
// - In beta mode status words leave bit by bit on the serial status output.
// - A low on the reset pin resets the logic; the pin may be push-pull or open-drain driven.
// - Link power status low past the short time zeroes control and data and ignores requests.
// - Link power status low past the long time, or hardware reset, disables the link clock.
module phyclr_top
(
  // System
  input wire logic CLK,
  input wire logic RSTN,
  // Pins
  input wire logic BETA_MODE_SELECT,
  input wire logic POWER_DOWN_IN,
  input wire logic LOGIC_RESET_N_IN,
  output logic LOGIC_RESET_N_OUT,
  output logic LOGIC_RESET_N_OE,
  input wire logic SCAN_TEST_ENABLE,
  input wire logic CABLE_ACTIVE_IN,
  output logic CABLE_ACTIVE_OUT,
  // Link side
  input wire logic LINK_POWER_STATUS,
  input wire logic LINK_REQUEST,
  output logic LINK_CLOCK_OUT,
  output logic [1:0] CONTROL_PAIR,
  output logic [7:0] DATA_OUT,
  output logic PHY_STATUS_SERIAL_OUT,
  // Registers
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [31:0] REG_RDATA,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: the first stage, sync_a, is read only by the second, sync_b
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] pins;
  assign pins = {CABLE_ACTIVE_IN, LINK_REQUEST, LINK_POWER_STATUS, SCAN_TEST_ENABLE,
                 LOGIC_RESET_N_IN, POWER_DOWN_IN};
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end
  logic pd_s, rstpin_s, scan_s, lps_s, link_request_s, cna_s;
  assign {cna_s, link_request_s, lps_s, scan_s, rstpin_s, pd_s} = sync_b;
  // Beta mode strap is static; two stages of its own, mode_a and beta_s, keep it out of the pin list above
  logic mode_a, beta_s;

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset: pin low, power-down or scan test all stop the logic
  logic int_rst;
  assign int_rst = !rstpin_s || pd_s || scan_s;
  // Counters must reach their end values, or the link would never time out
  if (phyclr_pkg::LPS_DISABLE_CYCLES >= (1 << phyclr_pkg::LPS_CNT_WIDTH) ||
      phyclr_pkg::LEGACY_HALF_CYCLES > 4 || phyclr_pkg::BETA_HALF_CYCLES < 1)
  begin : g_bad_counts
    $error("link timing counts do not fit their counters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state and power status timer
  phyclr_pkg::phyclr_link_state_type state, next_state;
  logic [phyclr_pkg::LPS_CNT_WIDTH-1:0] lps_cnt, next_lps_cnt;
  logic [1:0] div_cnt, next_div_cnt;
  logic lclk, next_lclk;
  logic link_request_d, next_link_request_d;
  logic [1:0] ctl_q, next_ctl_q;
  logic [7:0] data_q, next_data_q;
  logic lclk_rise;

  always_comb
  begin
    next_state = state;
    next_lps_cnt = lps_cnt;
    if (int_rst)
    begin
      next_state = phyclr_pkg::LINK_DISABLED;
      next_lps_cnt = '0;
    end
    else if (lps_s)
    begin
      next_lps_cnt = '0;
      next_state = phyclr_pkg::LINK_ACTIVE;
    end
    else
    begin
      if (lps_cnt != phyclr_pkg::LPS_CNT_WIDTH'(phyclr_pkg::LPS_DISABLE_CYCLES))
        next_lps_cnt = lps_cnt + 1'b1;
      if (lps_cnt >= phyclr_pkg::LPS_CNT_WIDTH'(phyclr_pkg::LPS_DISABLE_CYCLES))
        next_state = phyclr_pkg::LINK_DISABLED;
      else if (lps_cnt >= phyclr_pkg::LPS_CNT_WIDTH'(phyclr_pkg::LPS_RESET_CYCLES) &&
               state == phyclr_pkg::LINK_ACTIVE)
        next_state = phyclr_pkg::LINK_RESET;
    end
  end

  // Link clock divider, stopped only in the disabled state
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_lclk = lclk;
    if (state == phyclr_pkg::LINK_DISABLED)
    begin
      next_div_cnt = '0;
      next_lclk = 1'b0;
    end
    else if (div_cnt == 2'(beta_s ? phyclr_pkg::BETA_HALF_CYCLES - 1
                                  : phyclr_pkg::LEGACY_HALF_CYCLES - 1))
    begin
      next_div_cnt = '0;
      next_lclk = !lclk;
    end
    else
      next_div_cnt = div_cnt + 1'b1;
  end
  assign lclk_rise = next_lclk && !lclk;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [4:0] status, next_status;
  logic [4:0] enable, next_enable;
  logic [9:0] txdata, next_txdata;
  logic [7:0] ser_word, next_ser_word;
  logic [3:0] ser_left, next_ser_left;
  logic ser_out, next_ser_out;
  logic [31:0] next_rdata;
  logic [4:0] events;
  logic pd_d, next_pd_d;
  logic prev_state_active;

  assign prev_state_active = state == phyclr_pkg::LINK_ACTIVE;
  always_comb
  begin
    events = '0;
    events[phyclr_pkg::EV_RESET_STATE] = next_state == phyclr_pkg::LINK_RESET && prev_state_active;
    events[phyclr_pkg::EV_DISABLED] = next_state == phyclr_pkg::LINK_DISABLED &&
                                      state != phyclr_pkg::LINK_DISABLED;
    // Requests count only while the interface is active
    events[phyclr_pkg::EV_LINK_REQUEST] = link_request_s && !link_request_d && prev_state_active;
    events[phyclr_pkg::EV_SERIAL_DONE] = lclk_rise && ser_left == 4'h1;
    events[phyclr_pkg::EV_POWER_DOWN] = pd_s && !pd_d;
  end

  always_comb
  begin
    next_link_request_d = link_request_s;
    next_pd_d = pd_s;
    next_status = status | events;
    next_enable = enable;
    next_txdata = txdata;
    next_ser_word = ser_word;
    next_ser_left = ser_left;
    next_ser_out = ser_out;
    next_rdata = '0;
    // Set wins over clear
    if (REG_WRITE && REG_ADDR == phyclr_pkg::ADDR_CLEAR)
      next_status = (status & ~REG_WDATA[4:0]) | events;
    if (REG_WRITE && REG_ADDR == phyclr_pkg::ADDR_ENABLE)
      next_enable = REG_WDATA[4:0];
    if (REG_WRITE && REG_ADDR == phyclr_pkg::ADDR_TXDATA)
      next_txdata = REG_WDATA[9:0];
    // Serial status: a start bit of 1, then the word MSB first, one bit per link clock
    if (lclk_rise && ser_left != 4'h0)
    begin
      next_ser_out = ser_left == phyclr_pkg::SERIAL_BITS ? 1'b1 : ser_word[7];
      if (ser_left != phyclr_pkg::SERIAL_BITS)
        next_ser_word = {ser_word[6:0], 1'b0};
      next_ser_left = ser_left - 1'b1;
    end
    else if (lclk_rise)
      next_ser_out = 1'b0;
    // A write while busy is dropped so a word never tears
    if (REG_WRITE && REG_ADDR == phyclr_pkg::ADDR_SERIAL && ser_left == 4'h0 && beta_s)
    begin
      next_ser_word = REG_WDATA[7:0];
      next_ser_left = phyclr_pkg::SERIAL_BITS;
    end
    if (int_rst || !beta_s)
    begin
      next_txdata = phyclr_pkg::TXDATA_RESET;
      next_ser_word = phyclr_pkg::SERIAL_RESET;
      next_ser_left = '0;
      next_ser_out = 1'b0;
    end
    if (REG_READ)
    begin
      unique case (REG_ADDR)
        phyclr_pkg::ADDR_STATUS: next_rdata = {27'h0000000, status};
        phyclr_pkg::ADDR_ENABLE: next_rdata = {27'h0000000, enable};
        phyclr_pkg::ADDR_TXDATA: next_rdata = {22'h000000, txdata};
        phyclr_pkg::ADDR_SERIAL: next_rdata = {23'h000000, ser_left != 4'h0, ser_word};
        phyclr_pkg::ADDR_STATE: next_rdata = {25'h0000000, pd_s, beta_s, lps_s, state, 1'b0};
        default: next_rdata = '0;
      endcase
    end
    // Control and data follow the register on link clock rising edges, zero outside active
    next_ctl_q = ctl_q;
    next_data_q = data_q;
    if (state != phyclr_pkg::LINK_ACTIVE || int_rst)
    begin
      next_ctl_q = '0;
      next_data_q = '0;
    end
    else if (lclk_rise)
    begin
      next_ctl_q = txdata[phyclr_pkg::TX_CTL_LSB +: 2];
      next_data_q = txdata[phyclr_pkg::TX_DATA_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode_a <= 1'b0;
      beta_s <= 1'b0;
      state <= phyclr_pkg::LINK_DISABLED;
      lps_cnt <= '0;
      div_cnt <= '0;
      lclk <= 1'b0;
      link_request_d <= 1'b0;
      pd_d <= 1'b0;
      ctl_q <= '0;
      data_q <= '0;
      status <= '0;
      enable <= phyclr_pkg::ENABLE_RESET;
      txdata <= phyclr_pkg::TXDATA_RESET;
      ser_word <= phyclr_pkg::SERIAL_RESET;
      ser_left <= '0;
      ser_out <= 1'b0;
      REG_RDATA <= '0;
      IRQ <= 1'b0;
      LINK_CLOCK_OUT <= 1'b0;
      CONTROL_PAIR <= '0;
      DATA_OUT <= '0;
      PHY_STATUS_SERIAL_OUT <= 1'b0;
      CABLE_ACTIVE_OUT <= 1'b0;
      LOGIC_RESET_N_OUT <= 1'b0;
      LOGIC_RESET_N_OE <= 1'b0;
    end
    else
    begin
      mode_a <= BETA_MODE_SELECT;
      beta_s <= mode_a;
      state <= next_state;
      lps_cnt <= next_lps_cnt;
      div_cnt <= next_div_cnt;
      lclk <= next_lclk;
      link_request_d <= next_link_request_d;
      pd_d <= next_pd_d;
      ctl_q <= next_ctl_q;
      data_q <= next_data_q;
      status <= next_status;
      enable <= next_enable;
      txdata <= next_txdata;
      ser_word <= next_ser_word;
      ser_left <= next_ser_left;
      ser_out <= next_ser_out;
      REG_RDATA <= next_rdata;
      IRQ <= |(next_status & next_enable);
      LINK_CLOCK_OUT <= next_lclk;
      CONTROL_PAIR <= next_ctl_q;
      DATA_OUT <= next_data_q;
      PHY_STATUS_SERIAL_OUT <= next_ser_out;
      // Monitor path stays alive through power-down
      CABLE_ACTIVE_OUT <= cna_s;
      LOGIC_RESET_N_OUT <= 1'b0;
      LOGIC_RESET_N_OE <= pd_s;
    end
  end

endmodule : phyclr_top

// ---- verif/phyclr_chk.sv ----
`timescale 1ns/1ps
module phyclr_chk
(
  // System
  input wire logic CLK,
  input wire logic RSTN,
  // Pins
  input wire logic BETA_MODE_SELECT,
  input wire logic POWER_DOWN_IN,
  input wire logic LOGIC_RESET_N_IN,
  input wire logic LOGIC_RESET_N_OE,
  input wire logic CABLE_ACTIVE_IN,
  input wire logic CABLE_ACTIVE_OUT,
  // Link side
  input wire logic LINK_POWER_STATUS,
  input wire logic LINK_CLOCK_OUT,
  input wire logic [1:0] CONTROL_PAIR,
  input wire logic [7:0] DATA_OUT,
  input wire logic PHY_STATUS_SERIAL_OUT
);
  // Low-time limits include the input synchroniser and output register lag
  localparam int SHORT_LIM = 110;
  localparam int LONG_LIM = 1046;
  logic [10:0] low_cnt;
  logic [10:0] next_low_cnt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_low_cnt = low_cnt;
    if (LINK_POWER_STATUS)
      next_low_cnt = 11'h000;
    else if (low_cnt != 11'h7FF)
      next_low_cnt = low_cnt + 11'h001;
  end
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      low_cnt <= 11'h000;
    else
      low_cnt <= next_low_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_leg_rise;
    (!BETA_MODE_SELECT && !POWER_DOWN_IN) [*5] ##0 $rose(LINK_CLOCK_OUT);
  endsequence
  property p_legacy_clk;
    s_leg_rise |=> LINK_CLOCK_OUT;
  endproperty
  a_legacy_clk: assert property (p_legacy_clk) else $error("legacy high too short");
  property p_beta_clk;
    BETA_MODE_SELECT [*5] ##0 LINK_CLOCK_OUT |=> !LINK_CLOCK_OUT;
  endproperty
  a_beta_clk: assert property (p_beta_clk) else $error("beta clock high too long");
  property p_pd_oe;
    POWER_DOWN_IN [*5] |-> LOGIC_RESET_N_OE && !LINK_CLOCK_OUT;
  endproperty
  a_pd_oe: assert property (p_pd_oe) else $error("reset pin not pulled");
  property p_cable;
    $stable(CABLE_ACTIVE_IN) [*4] |-> CABLE_ACTIVE_OUT == CABLE_ACTIVE_IN;
  endproperty
  a_cable: assert property (p_cable) else $error("cable output lost");
  property p_short;
    low_cnt >= SHORT_LIM |-> CONTROL_PAIR == 2'h0 && DATA_OUT == 8'h00;
  endproperty
  a_short: assert property (p_short) else $error("link outputs not zero");
  property p_long;
    low_cnt >= LONG_LIM |-> !LINK_CLOCK_OUT;
  endproperty
  a_long: assert property (p_long) else $error("link clock running");
  property p_hw_reset;
    $rose(RSTN) |-> !LINK_CLOCK_OUT ##1 !LINK_CLOCK_OUT;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("clock after reset");
  property p_leg_serial;
    !BETA_MODE_SELECT [*5] |-> !PHY_STATUS_SERIAL_OUT;
  endproperty
  a_leg_serial: assert property (p_leg_serial) else $error("serial active");
  property p_pin_reset;
    !LOGIC_RESET_N_IN [*5] |-> !LINK_CLOCK_OUT && DATA_OUT == 8'h00 && !PHY_STATUS_SERIAL_OUT;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("logic not reset");
endmodule : phyclr_chk
bind phyclr_top phyclr_chk chk
(
  .CLK(CLK), .RSTN(RSTN), .BETA_MODE_SELECT(BETA_MODE_SELECT), .POWER_DOWN_IN(POWER_DOWN_IN),
  .LOGIC_RESET_N_IN(LOGIC_RESET_N_IN), .LOGIC_RESET_N_OE(LOGIC_RESET_N_OE),
  .CABLE_ACTIVE_IN(CABLE_ACTIVE_IN), .CABLE_ACTIVE_OUT(CABLE_ACTIVE_OUT),
  .LINK_POWER_STATUS(LINK_POWER_STATUS), .LINK_CLOCK_OUT(LINK_CLOCK_OUT),
  .CONTROL_PAIR(CONTROL_PAIR), .DATA_OUT(DATA_OUT), .PHY_STATUS_SERIAL_OUT(PHY_STATUS_SERIAL_OUT)
);

// ---- verif/phyclr_link_model.sv ----
`timescale 1ns/1ps
module phyclr_link_model
(
  // Bench side
  input wire logic clk,
  input wire logic power_on,
  input wire logic req_cmd,
  // Link pins
  input wire logic link_clock,
  output logic link_power_status,
  output bit link_request,
  output int rise_count
);
  bit last_clock;
  // Requests only move on link clock rises, as a real controller would
  assign link_power_status = power_on;
  always @(posedge clk)
  begin
    last_clock <= link_clock;
    if (link_clock && !last_clock)
    begin
      rise_count <= rise_count + 1;
      link_request <= req_cmd;
    end
  end
endmodule : phyclr_link_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, beta, pd, cable_in, scan, power_on, req_cmd, ext_low, wr, rd, irq;
  logic rst_pin, rst_out, rst_oe, cable_out, link_request, link_power_status, lclk, serial_out;
  logic [1:0] ctl;
  logic [7:0] data, addr;
  logic [31:0] wdata, rdata, v;
  int bad_count, samples_checked, rises, n;
  // Open-drain reset wire with pull-up; either party may pull it low
  assign rst_pin = !((rst_oe && !rst_out) || ext_low);
  phyclr_top uut
  (
    .CLK(clk), .RSTN(rstn), .BETA_MODE_SELECT(beta), .POWER_DOWN_IN(pd),
    .LOGIC_RESET_N_IN(rst_pin), .LOGIC_RESET_N_OUT(rst_out), .LOGIC_RESET_N_OE(rst_oe),
    .SCAN_TEST_ENABLE(scan), .CABLE_ACTIVE_IN(cable_in), .CABLE_ACTIVE_OUT(cable_out),
    .LINK_POWER_STATUS(link_power_status), .LINK_REQUEST(link_request), .LINK_CLOCK_OUT(lclk), .CONTROL_PAIR(ctl),
    .DATA_OUT(data), .PHY_STATUS_SERIAL_OUT(serial_out), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WRITE(wr), .REG_READ(rd), .REG_RDATA(rdata), .IRQ(irq)
  );
  phyclr_link_model link
  (
    .clk(clk), .power_on(power_on), .req_cmd(req_cmd), .link_clock(lclk), .link_power_status(link_power_status),
    .link_request(link_request), .rise_count(rises)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rreg
  task automatic pulse_req;
    @(posedge clk);
    req_cmd <= 1'b1;
    cyc(6);
    @(posedge clk);
    req_cmd <= 1'b0;
    cyc(6);
  endtask : pulse_req
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #100000;
    bad_count++;
    close_out();
  end
  initial
  begin
    {rstn, pd, cable_in, power_on, req_cmd, ext_low, wr, rd, addr, wdata} = '0;
    beta = 1'b1;
    scan = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cyc(3);
    check(32'(lclk), 32'h0);
    rreg(phyclr_pkg::ADDR_STATE);
    check(v & 32'hE, 32'h2);
    rreg(8'h40);
    check(v, 32'h0);
    @(posedge clk);
    power_on <= 1'b1;
    cyc(10);
    n = rises;
    cyc(40);
    check(32'(rises - n), 32'h14);
    wreg(phyclr_pkg::ADDR_TXDATA, 32'h2A5);
    cyc(6);
    check({22'h0, ctl, data}, 32'h2A5);
    wreg(phyclr_pkg::ADDR_ENABLE, 32'h8);
    wreg(phyclr_pkg::ADDR_SERIAL, 32'h96);
    n = 0;
    while (serial_out !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(serial_out), 32'h1);
    for (int i = 7; i >= 0; i--)
    begin
      cyc(2);
      check(32'(serial_out), 32'((8'h96 >> i) & 8'h1));
    end
    cyc(6);
    check(32'(irq), 32'h1);
    wreg(phyclr_pkg::ADDR_CLEAR, 32'h1F);
    wreg(phyclr_pkg::ADDR_ENABLE, 32'h0);
    pulse_req();
    rreg(phyclr_pkg::ADDR_STATUS);
    check(v & 32'h4, 32'h4);
    check(32'(irq), 32'h0);
    wreg(phyclr_pkg::ADDR_ENABLE, 32'h4);
    cyc(2);
    check(32'(irq), 32'h1);
    wreg(phyclr_pkg::ADDR_CLEAR, 32'h1F);
    cyc(2);
    check(32'(irq), 32'h0);
    @(posedge clk);
    power_on <= 1'b0;
    cyc(115);
    check({22'h0, ctl, data}, 32'h0);
    rreg(phyclr_pkg::ADDR_STATE);
    check(v & 32'hE, 32'h4);
    n = rises;
    pulse_req();
    check(32'(rises > n), 32'h1);
    rreg(phyclr_pkg::ADDR_STATUS);
    check(v & 32'h4, 32'h0);
    cyc(1000);
    n = rises;
    cyc(10);
    check(32'(rises - n), 32'h0);
    rreg(phyclr_pkg::ADDR_STATE);
    check(v & 32'hE, 32'h2);
    @(posedge clk);
    power_on <= 1'b1;
    cyc(10);
    wreg(phyclr_pkg::ADDR_TXDATA, 32'h155);
    cyc(6);
    check(32'(data), 32'h55);
    @(posedge clk);
    ext_low <= 1'b1;
    cyc(8);
    check(32'(data), 32'h0);
    @(posedge clk);
    ext_low <= 1'b0;
    cyc(10);
    rreg(phyclr_pkg::ADDR_TXDATA);
    check(v, 32'h0);
    @(posedge clk);
    beta <= 1'b0;
    cyc(10);
    n = rises;
    cyc(40);
    check(32'(rises - n), 32'hA);
    wreg(phyclr_pkg::ADDR_SERIAL, 32'hFF);
    n = 0;
    repeat (30)
    begin
      @(negedge clk);
      n += int'(serial_out !== 1'b0);
    end
    check(32'(n), 32'h0);
    rreg(phyclr_pkg::ADDR_SERIAL);
    check(v, 32'h0);
    @(posedge clk);
    pd <= 1'b1;
    cable_in <= 1'b1;
    cyc(8);
    check({30'h0, rst_oe, rst_out}, 32'h2);
    check({30'h0, lclk, cable_out}, 32'h1);
    @(posedge clk);
    pd <= 1'b0;
    cyc(8);
    check(32'(rst_oe), 32'h0);
    // Status survives internal reset: reset state, disabled and power-down events remain
    rreg(phyclr_pkg::ADDR_STATUS);
    check(v, 32'h13);
    rreg(phyclr_pkg::ADDR_ENABLE);
    check(v, 32'h4);
    close_out();
  end
endmodule : tb_top
